// [core/vrc_map.svh]
// vrc_map.svh: pin-level timing counts and address widths for the video memory cycle driver
// assumes a 20 MHz system clock; the memory pins are driven straight from flip-flops
//
// Behaviour
// - transfer-select low at row strobe fall picks transfer, high picks random access
// - controller holds the multiplexed address stable before each strobe falls
// - transfer, write high, special high: split read, controller supplies fresh tap
// - persistent masking needs write-enable high during the mask-register load cycle
`ifndef VRC_MAP_SVH
`define VRC_MAP_SVH

`define VRC_CLK_NS      50
`define VRC_ADDR_W      9
`define VRC_DQ_W        4
`define VRC_TMR_W       4

// phase lengths in ns, turned into whole clock cycles rounded up
`define VRC_T_ASR_NS    50
`define VRC_T_RCD_NS    100
`define VRC_T_ASC_NS    50
`define VRC_T_CAS_NS    100
`define VRC_T_RP_NS     150
`define VRC_T_CBR_NS    200
`define VRC_CYC(ns)     (((ns) + `VRC_CLK_NS - 1) / `VRC_CLK_NS)

`define VRC_REF_RST     9'h000

`endif

// [core/vrc_pkg.sv]
// vrc_pkg.sv: command and state types of the video memory cycle driver
// assumes the constants of vrc_map.svh are included where numbers are needed
package vrc_pkg;

    // ******************************************************
    // user commands, one per documented cycle kind
    // ******************************************************
    typedef enum logic [3:0] {
        VRC_REFRESH     = 4'h0,
        VRC_XFER_WRITE  = 4'h1,
        VRC_ALT_WRITE   = 4'h2,
        VRC_PSEUDO_WR   = 4'h3,
        VRC_XFER_READ   = 4'h4,
        VRC_SPLIT_READ  = 4'h5,
        VRC_WR_MASKED   = 4'h6,
        VRC_BLK_MASKED  = 4'h7,
        VRC_WR_PERSIST  = 4'h8,
        VRC_BLK_PERSIST = 4'h9,
        VRC_READ        = 4'hA,
        VRC_WRITE       = 4'hB,
        VRC_BLK_WRITE   = 4'hC,
        VRC_LOAD_MASK   = 4'hD,
        VRC_LOAD_COLOR  = 4'hE
    } vrc_cmd_e;

    // ******************************************************
    // strobe sequencer states
    // ******************************************************
    typedef enum logic [5:0] {
        VRC_IDLE = 6'h01,
        VRC_ROW  = 6'h02,
        VRC_RASL = 6'h04,
        VRC_COL  = 6'h08,
        VRC_CASL = 6'h10,
        VRC_PRE  = 6'h20
    } vrc_state_e;

endpackage : vrc_pkg

// [core/vrc_phase_timer.sv]
// vrc_phase_timer.sv: down counter that times one strobe phase
// assumes load_in pulses in the last cycle before each phase, so the count is loaded as the phase starts
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_phase_timer #(
    parameter int W = `VRC_TMR_W
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] len_in,
    output logic              expired_out
);
    logic [W-1:0] count_reg;

    // a phase of len cycles ends when the count reaches zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else if (load_in) begin
            count_reg <= len_in - W'(1);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    // expiry looks at the count alone: the load is decided from expiry, so gating
    // the flag with load would close a combinational loop through the sequencer
    assign expired_out = (count_reg == '0);
endmodule : vrc_phase_timer

// [core/vrc_cycle_driver.sv]
// vrc_cycle_driver.sv: controller that runs one video memory cycle per user command
// assumes the memory samples its pins on strobe edges; all pins leave here from flip-flops
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_cycle_driver
    import vrc_pkg::*;
#(
    parameter int T_ROW  = `VRC_CYC(`VRC_T_ASR_NS),
    parameter int T_RASL = `VRC_CYC(`VRC_T_RCD_NS),
    parameter int T_COL  = `VRC_CYC(`VRC_T_ASC_NS),
    parameter int T_CASL = `VRC_CYC(`VRC_T_CAS_NS),
    parameter int T_PRE  = `VRC_CYC(`VRC_T_RP_NS),
    parameter int T_CBR  = `VRC_CYC(`VRC_T_CBR_NS)
) (
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     cmd_valid_in,
    input  wire logic [3:0]               cmd_in,
    input  wire logic [`VRC_ADDR_W-1:0]   row_in,
    input  wire logic [`VRC_ADDR_W-1:0]   col_in,
    input  wire logic [`VRC_DQ_W-1:0]     data_in,
    input  wire logic [`VRC_DQ_W-1:0]     mask_in,
    output logic                          cmd_ready_out,
    output logic                          done_out,
    output logic [`VRC_DQ_W-1:0]          rdata_out,
    output logic                          ras_n_out,
    output logic                          cas_n_out,
    output logic                          transfer_select_n_out,
    output logic                          write_enable_n_out,
    output logic                          special_function_sel_out,
    output logic                          serial_port_enable_n_out,
    output logic [`VRC_ADDR_W-1:0]        mux_address_out,
    output logic [`VRC_DQ_W-1:0]          random_data_out,
    output logic                          random_data_oe_out,
    input  wire logic [`VRC_DQ_W-1:0]     random_data_in
);
    localparam int AW = `VRC_ADDR_W;
    localparam int DW = `VRC_DQ_W;
    localparam int TW = `VRC_TMR_W;

    vrc_state_e    state_reg, state_next;
    vrc_cmd_e      cmd_reg, cmd_cur;
    logic [AW-1:0] row_reg, col_reg, row_cur, col_cur, refresh_row_reg;
    logic [DW-1:0] data_reg, mask_reg, data_cur, mask_cur;
    logic          accept, expired, tmr_load;
    logic [TW-1:0] tmr_len;
    // levels of the cycle presented at row strobe fall and at column strobe fall
    logic lv_cbr, lv_trg_n, lv_we_n, lv_dsf_r, lv_se_n, lv_dsf_c;
    logic lv_dq_ras, lv_wr, lv_rd, lv_refaddr;
    // pin next values
    logic          ras_next, cas_next, trg_next, we_next, dsf_next, se_next, oe_next;
    logic [AW-1:0] addr_next;
    logic [DW-1:0] dq_next;

    // ******************************************************
    // command acceptance and operand capture
    // ******************************************************
    assign accept   = (state_reg == VRC_IDLE) && cmd_valid_in;
    assign cmd_cur  = accept ? vrc_cmd_e'(cmd_in) : cmd_reg;
    assign row_cur  = accept ? row_in  : row_reg;
    assign col_cur  = accept ? col_in  : col_reg;
    assign data_cur = accept ? data_in : data_reg;
    assign mask_cur = accept ? mask_in : mask_reg;

    // operands held for the whole cycle so the pins stay stable around each strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_reg  <= VRC_REFRESH;
            row_reg  <= '0;
            col_reg  <= '0;
            data_reg <= '0;
            mask_reg <= '0;
        end else if (accept) begin
            cmd_reg  <= vrc_cmd_e'(cmd_in);
            row_reg  <= row_in;
            col_reg  <= col_in;
            data_reg <= data_in;
            mask_reg <= mask_in;
        end
    end

    // ******************************************************
    // cycle table: levels per command
    // ******************************************************
    // unknown codes fall back to a refresh, a cycle that cannot corrupt data
    always_comb begin
        lv_cbr = 1'b0; lv_trg_n = 1'b1; lv_we_n = 1'b1; lv_dsf_r = 1'b0; lv_se_n = 1'b1;
        lv_dsf_c = 1'b0; lv_dq_ras = 1'b0; lv_wr = 1'b0; lv_rd = 1'b0; lv_refaddr = 1'b0;
        case (cmd_cur)
            VRC_XFER_WRITE: begin lv_trg_n = 1'b0; lv_we_n = 1'b0; lv_se_n = 1'b0; end
            VRC_ALT_WRITE:  begin lv_trg_n = 1'b0; lv_we_n = 1'b0; lv_dsf_r = 1'b1; end
            VRC_PSEUDO_WR:  begin lv_trg_n = 1'b0; lv_we_n = 1'b0; lv_refaddr = 1'b1; end
            VRC_XFER_READ:  begin lv_trg_n = 1'b0; end
            VRC_SPLIT_READ: begin lv_trg_n = 1'b0; lv_dsf_r = 1'b1; end
            VRC_WR_MASKED:  begin lv_we_n = 1'b0; lv_dq_ras = 1'b1; lv_wr = 1'b1; end
            VRC_BLK_MASKED: begin
                lv_we_n = 1'b0; lv_dq_ras = 1'b1; lv_dsf_c = 1'b1; lv_wr = 1'b1;
            end
            VRC_WR_PERSIST: begin lv_we_n = 1'b0; lv_dsf_r = 1'b1; lv_wr = 1'b1; end
            VRC_BLK_PERSIST: begin
                lv_we_n = 1'b0; lv_dsf_r = 1'b1; lv_dsf_c = 1'b1; lv_wr = 1'b1;
            end
            VRC_READ:       begin lv_rd = 1'b1; end
            VRC_WRITE:      begin lv_wr = 1'b1; end
            VRC_BLK_WRITE:  begin lv_dsf_c = 1'b1; lv_wr = 1'b1; end
            VRC_LOAD_MASK:  begin lv_dsf_r = 1'b1; lv_wr = 1'b1; lv_refaddr = 1'b1; end
            VRC_LOAD_COLOR: begin
                lv_dsf_r = 1'b1; lv_dsf_c = 1'b1; lv_wr = 1'b1; lv_refaddr = 1'b1;
            end
            default:        begin lv_cbr = 1'b1; end
        endcase
    end

    // ******************************************************
    // strobe sequencer
    // ******************************************************
    // refresh skips the column phases: the column strobe is already low before the row strobe
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            VRC_IDLE: if (cmd_valid_in) state_next = VRC_ROW;
            VRC_ROW:  if (expired) state_next = VRC_RASL;
            VRC_RASL: if (expired) state_next = lv_cbr ? VRC_PRE : VRC_COL;
            VRC_COL:  if (expired) state_next = VRC_CASL;
            VRC_CASL: if (expired) state_next = VRC_PRE;
            VRC_PRE:  if (expired) state_next = VRC_IDLE;
            default:  state_next = VRC_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= VRC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // phase length chosen for the state being entered
    always_comb begin
        tmr_load = (state_next != state_reg);
        case (state_next)
            VRC_ROW:  tmr_len = TW'(T_ROW);
            VRC_RASL: tmr_len = lv_cbr ? TW'(T_CBR) : TW'(T_RASL);
            VRC_COL:  tmr_len = TW'(T_COL);
            VRC_CASL: tmr_len = TW'(T_CASL);
            VRC_PRE:  tmr_len = TW'(T_PRE);
            default:  tmr_len = TW'(1);
        endcase
    end

    vrc_phase_timer #(.W(TW)) u_timer (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .load_in     (tmr_load),
        .len_in      (tmr_len),
        .expired_out (expired)
    );

    // ******************************************************
    // pin levels for the coming state
    // ******************************************************
    always_comb begin
        ras_next = 1'b1; cas_next = 1'b1; trg_next = 1'b1; we_next = 1'b1;
        dsf_next = 1'b0; se_next = 1'b1; oe_next = 1'b0;
        addr_next = mux_address_out;
        dq_next   = random_data_out;
        case (state_next)
            VRC_ROW, VRC_RASL: begin
                ras_next = (state_next != VRC_RASL);
                if (lv_cbr) begin
                    cas_next = 1'b0;
                end else begin
                    addr_next = lv_refaddr ? refresh_row_reg : row_cur;
                    trg_next  = lv_trg_n;
                    we_next   = lv_we_n;
                    dsf_next  = lv_dsf_r;
                    se_next   = lv_se_n;
                    oe_next   = lv_dq_ras;
                    dq_next   = mask_cur;
                end
            end
            VRC_COL, VRC_CASL: begin
                ras_next  = 1'b0;
                cas_next  = (state_next != VRC_CASL);
                addr_next = col_cur;
                dsf_next  = lv_dsf_c;
                trg_next  = !lv_rd;
                we_next   = !lv_wr;
                oe_next   = lv_wr;
                dq_next   = data_cur;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ras_n_out <= 1'b1; cas_n_out <= 1'b1; transfer_select_n_out <= 1'b1;
            write_enable_n_out <= 1'b1; special_function_sel_out <= 1'b0;
            serial_port_enable_n_out <= 1'b1; random_data_oe_out <= 1'b0;
            mux_address_out <= '0; random_data_out <= '0;
        end else begin
            ras_n_out <= ras_next; cas_n_out <= cas_next; transfer_select_n_out <= trg_next;
            write_enable_n_out <= we_next; special_function_sel_out <= dsf_next;
            serial_port_enable_n_out <= se_next; random_data_oe_out <= oe_next;
            mux_address_out <= addr_next; random_data_out <= dq_next;
        end
    end

    // ******************************************************
    // handshake, read data and refresh row counter
    // ******************************************************
    // read data taken on the last cycle of the column strobe low phase, when it has settled
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_ready_out   <= 1'b0;
            done_out        <= 1'b0;
            rdata_out       <= '0;
            refresh_row_reg <= `VRC_REF_RST;
        end else begin
            cmd_ready_out <= (state_next == VRC_IDLE);
            done_out      <= (state_reg == VRC_PRE) && expired;
            if ((state_reg == VRC_CASL) && expired && lv_rd) begin
                rdata_out <= random_data_in;
            end
            if ((state_reg == VRC_PRE) && expired && lv_refaddr) begin
                refresh_row_reg <= refresh_row_reg + AW'(1);
            end
        end
    end

    // ******************************************************
    // checks
    // ******************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic is_xfer;
    assign is_xfer = !lv_cbr && !lv_trg_n;

    a_sel_at_ras: assert property ($fell(ras_n_out) && !lv_cbr
        |-> transfer_select_n_out == !is_xfer)
        else $error("transfer select wrong at row strobe fall");
    a_row_addr: assert property ($fell(ras_n_out) && !lv_cbr && !lv_refaddr
        |-> mux_address_out == row_reg && $stable(mux_address_out))
        else $error("row address wrong at row strobe fall");
    a_col_addr: assert property ($fell(cas_n_out) && !lv_cbr
        |-> mux_address_out == col_reg && $past(mux_address_out) == col_reg)
        else $error("column address not stable at column strobe fall");
    a_cbr_order: assert property ($fell(ras_n_out) && lv_cbr
        |-> !cas_n_out && !$past(cas_n_out))
        else $error("refresh without column strobe first");
    a_xfer_dq_off: assert property (!ras_n_out && is_xfer |-> !random_data_oe_out)
        else $error("data pins driven in a transfer cycle");
    a_mask_at_ras: assert property ($fell(ras_n_out) && lv_dq_ras
        |-> random_data_oe_out && random_data_out == mask_reg && !write_enable_n_out)
        else $error("write mask missing at row strobe fall");
    a_pseudo_levels: assert property ($fell(ras_n_out) && cmd_reg == VRC_PSEUDO_WR
        |-> !write_enable_n_out && !special_function_sel_out && serial_port_enable_n_out)
        else $error("pseudo transfer levels wrong");
    a_load_we_high: assert property ($fell(ras_n_out) && (cmd_reg == VRC_LOAD_MASK)
        |-> write_enable_n_out && special_function_sel_out)
        else $error("mask load without write-enable high");
    a_write_data: assert property ($fell(cas_n_out) && lv_wr
        |-> !write_enable_n_out && random_data_oe_out && random_data_out == data_reg)
        else $error("write data not present at column strobe fall");
    a_cas_dsf: assert property ($fell(cas_n_out) |-> special_function_sel_out == lv_dsf_c)
        else $error("special function wrong at column strobe fall");
    a_read_oe: assert property (!cas_n_out && lv_rd |-> !transfer_select_n_out)
        else $error("read without output enable");
    a_done_bound: assert property (accept |-> ##[8:30] done_out)
        else $error("cycle did not finish in time");

    c_refresh: cover property (accept && cmd_in == VRC_REFRESH ##[1:30] done_out);
    c_xfer_read: cover property ($fell(ras_n_out) && cmd_reg == VRC_XFER_READ);
    c_blk_masked: cover property ($fell(cas_n_out) && cmd_reg == VRC_BLK_MASKED);
    c_read_back: cover property ($fell(cas_n_out) && lv_rd ##[1:8] done_out);
endmodule : vrc_cycle_driver

// [test/vrc_mem_model.sv]
// vrc_mem_model.sv: behavioural video memory random port that decodes every strobe cycle
// assumes the controller drives all pins from flip-flops on clk_in; no pull-ups on data pins
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_mem_model
    import vrc_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   ras_n_in,
    input  wire logic                   cas_n_in,
    input  wire logic                   transfer_select_n_in,
    input  wire logic                   write_enable_n_in,
    input  wire logic                   special_function_sel_in,
    input  wire logic                   serial_port_enable_n_in,
    input  wire logic [`VRC_ADDR_W-1:0] mux_address_in,
    input  wire logic [`VRC_DQ_W-1:0]   dq_ctl_in,
    input  wire logic                   dq_oe_in,
    output logic [`VRC_DQ_W-1:0]        dq_out,
    output logic [3:0]                  seen_cmd_out,
    output logic [`VRC_ADDR_W-1:0]      seen_row_out,
    output logic [`VRC_ADDR_W-1:0]      seen_col_out,
    output logic [`VRC_ADDR_W-1:0]      tap_out
);
    // ******************************************************
    // array, registers and data pin level
    // ******************************************************
    // full 18-bit cell space as a plain array, left uninitialised; cells never written read back as X
    logic [`VRC_DQ_W-1:0] mem [0:262143];
    logic [`VRC_DQ_W-1:0] wmask, color, ras_dq, last_dq;
    logic                 xfer, cas_first, wr_sel, dsf_ras, is_rd;

    // a released line toggles each cycle so a stale value never looks valid
    always @(posedge clk_in) last_dq <= dq_out;
    assign is_rd = !xfer && !cas_first && !cas_n_in
                   && !transfer_select_n_in && !dq_oe_in;
    assign dq_out = dq_oe_in ? dq_ctl_in : is_rd ? mem[{seen_row_out, seen_col_out}] : ~last_dq;

    // row strobe fall fixes the cycle family
    always @(negedge ras_n_in) begin
        cas_first = !cas_n_in;
        xfer = !cas_first && !transfer_select_n_in;
        wr_sel = !write_enable_n_in;
        dsf_ras = special_function_sel_in;
        ras_dq = dq_out;
        seen_row_out = mux_address_in;
        if (cas_first) seen_cmd_out = VRC_REFRESH;
        else if (xfer && wr_sel && dsf_ras) seen_cmd_out = VRC_ALT_WRITE;
        else if (xfer && wr_sel && serial_port_enable_n_in) seen_cmd_out = VRC_PSEUDO_WR;
        else if (xfer && wr_sel) seen_cmd_out = VRC_XFER_WRITE;
        else if (xfer) seen_cmd_out = dsf_ras ? VRC_SPLIT_READ : VRC_XFER_READ;
        else seen_cmd_out = 4'hF;
    end

    function automatic logic [3:0] rand_code(input logic dc, input logic wc);
        if (wr_sel) begin
            if (dsf_ras) return dc ? VRC_BLK_PERSIST : VRC_WR_PERSIST;
            return dc ? VRC_BLK_MASKED : VRC_WR_MASKED;
        end
        if (dsf_ras) return dc ? VRC_LOAD_COLOR : VRC_LOAD_MASK;
        return dc ? VRC_BLK_WRITE : (wc ? VRC_WRITE : VRC_READ);
    endfunction : rand_code

    // data is taken on the later of write-enable fall and column strobe fall
    task automatic capture();
        logic [`VRC_DQ_W-1:0] m;
        logic [17:0]          a;
        m = !wr_sel ? 4'hF : dsf_ras ? wmask : ras_dq;
        a = {seen_row_out, seen_col_out};
        case (seen_cmd_out)
            VRC_LOAD_MASK:  wmask = dq_out;
            VRC_LOAD_COLOR: color = dq_out;
            VRC_WR_MASKED, VRC_WR_PERSIST, VRC_WRITE: mem[a] = (mem[a] & ~m) | (dq_out & m);
            VRC_BLK_MASKED, VRC_BLK_PERSIST, VRC_BLK_WRITE: begin
                for (int i = 0; i < 4; i++) begin
                    a[1:0] = 2'(i);
                    if (dq_out[i]) mem[a] = (mem[a] & ~m) | (color & m);
                end
            end
            default: ;
        endcase
    endtask : capture

    // column strobe fall: column, tap and final random kind
    always @(negedge cas_n_in) begin
        if (!ras_n_in && xfer) tap_out = mux_address_in;
        if (!ras_n_in) seen_col_out = mux_address_in;
        if (!ras_n_in && !xfer && !cas_first) begin
            seen_cmd_out = rand_code(special_function_sel_in, !write_enable_n_in);
        end
        if (!ras_n_in && !xfer && !cas_first && !write_enable_n_in) capture();
    end
    always @(negedge write_enable_n_in) if (!cas_n_in && !ras_n_in && !xfer) capture();
endmodule : vrc_mem_model

// [test/testbench.sv]
// testbench.sv: runs every command kind through the controller into the memory model
// assumes the default phase counts of the controller
`timescale 1ns/1ps
`include "vrc_map.svh"
module testbench
    import vrc_pkg::*;
;
    logic clk_in, rst_in, cmd_valid, cmd_ready, done, ras_n, cas_n, trg_n, we_n, special_function_sel, se_n, oe;
    logic [3:0] cmd, data, mask, rdata, dq_out, dq_in, seen_cmd;
    logic [8:0] row, col, addr, seen_row, seen_col, tap;
    int         miscompares, n_tests;

    vrc_cycle_driver dut (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
        .cmd_in(cmd), .row_in(row), .col_in(col), .data_in(data), .mask_in(mask),
        .cmd_ready_out(cmd_ready), .done_out(done), .rdata_out(rdata), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .transfer_select_n_out(trg_n), .write_enable_n_out(we_n),
        .special_function_sel_out(special_function_sel), .serial_port_enable_n_out(se_n),
        .mux_address_out(addr), .random_data_out(dq_out), .random_data_oe_out(oe),
        .random_data_in(dq_in));
    vrc_mem_model mem (.clk_in(clk_in), .ras_n_in(ras_n), .cas_n_in(cas_n),
        .transfer_select_n_in(trg_n), .write_enable_n_in(we_n), .special_function_sel_in(special_function_sel),
        .serial_port_enable_n_in(se_n), .mux_address_in(addr), .dq_ctl_in(dq_out),
        .dq_oe_in(oe), .dq_out(dq_in), .seen_cmd_out(seen_cmd), .seen_row_out(seen_row),
        .seen_col_out(seen_col), .tap_out(tap));

    // ******************************************************
    // clock, compare, command and closing tasks
    // ******************************************************
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // one command, offered at a falling edge once ready, done counted from the take edge
    task automatic run(input logic [3:0] c, input logic [8:0] r, input logic [8:0] k,
                       input logic [3:0] d, input logic [3:0] m);
        int n;
        n = 0;
        @(negedge clk_in);
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        {cmd_valid, cmd, row, col, data, mask} = {1'b1, c, r, k, d, m};
        @(posedge clk_in);
        @(negedge clk_in);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        // phase sum: 1+4+3 for refresh (code F too), 1+2+1+2+3 for every other cycle
        cmp("done latency", (c == 4'h0 || c == 4'hF) ? 9'd8 : 9'd9, 9'(n));
    endtask : run

    task automatic rd(input logic [8:0] r, input logic [8:0] k, input logic [3:0] exp);
        run(VRC_READ, r, k, 4'h0, 4'h0);
        cmp("read data", 9'(exp), 9'(rdata));
    endtask : rd

    task automatic wrap_up();
        $display("counts: %0d compared, %0d mismatched", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // ******************************************************
    // scenarios
    // ******************************************************
    task automatic t_reset();
        repeat (16) @(negedge clk_in);
        cmp("reset pins", 9'h00F, 9'({ras_n, cas_n, trg_n, we_n}) | 9'({oe, cmd_ready, done}));
        rst_in = 1'b0;
        @(posedge clk_in);
        #1;
        cmp("ready after reset", 9'h001, 9'(cmd_ready));
        $display("test reset done");
    endtask : t_reset

    // every code once; the model reports how the memory decoded the cycle
    task automatic t_decode();
        logic [8:0] r, k, kind, ref_row;
        ref_row = 9'h000;
        // code F is unassigned and must come out as a refresh
        for (int c = 0; c < 16; c++) begin
            r = 9'h1C0 + 9'(c);
            k = 9'h0A0 + 9'(c);
            kind = (c == 15) ? 9'h000 : 9'(c);
            run(4'(c), r, k, 4'h0, 4'h0);
            cmp("cycle kind", kind, 9'(seen_cmd));
            // refresh-address cycles walk the internal row counter from zero
            if (c inside {3, 13, 14}) begin
                cmp("refresh row", ref_row, seen_row);
                ref_row = ref_row + 9'h001;
            end else if (c != 0 && c != 15) begin
                cmp("row", r, seen_row);
            end
            if (c inside {[1:5]}) cmp("tap", k, tap);
            else if (c > 5 && c < 13) cmp("column", k, seen_col);
        end
        $display("test decode done");
    endtask : t_decode

    // 0xC, then mask 0x5 with data 0 gives 0x8, then stored mask 0x3 with 0xF gives 0xB
    task automatic t_write();
        run(VRC_WRITE, 9'h155, 9'h0AA, 4'hC, 4'h0);
        rd(9'h155, 9'h0AA, 4'hC);
        run(VRC_WR_MASKED, 9'h155, 9'h0AA, 4'h0, 4'h5);
        rd(9'h155, 9'h0AA, 4'h8);
        run(VRC_LOAD_MASK, 9'h000, 9'h000, 4'h3, 4'h0);
        run(VRC_WR_PERSIST, 9'h155, 9'h0AA, 4'hF, 4'h0);
        rd(9'h155, 9'h0AA, 4'hB);
        $display("test write done");
    endtask : t_write

    // colour 0x9 into columns 0 and 2; then stored mask 0x3 on column 3: 0x6 becomes 0x5
    task automatic t_block();
        for (int i = 0; i < 4; i++) run(VRC_WRITE, 9'h0F0, 9'h1F0 + 9'(i), 4'h6, 4'h0);
        run(VRC_LOAD_COLOR, 9'h000, 9'h000, 4'h9, 4'h0);
        run(VRC_BLK_WRITE, 9'h0F0, 9'h1F0, 4'h5, 4'h0);
        for (int i = 0; i < 4; i++) rd(9'h0F0, 9'h1F0 + 9'(i), i[0] ? 4'h6 : 4'h9);
        run(VRC_BLK_PERSIST, 9'h0F0, 9'h1F0, 4'h8, 4'h0);
        rd(9'h0F0, 9'h1F3, 4'h5);
        $display("test block done");
    endtask : t_block

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        miscompares++;
        wrap_up();
    end

    initial begin
        {rst_in, cmd_valid, cmd, row, col, data, mask} = {1'b1, 1'b0, 4'h0, 9'h000, 9'h000, 8'h00};
        miscompares = 0;
        n_tests = 0;
        t_reset();
        t_decode();
        t_write();
        t_block();
        wrap_up();
    end
endmodule : testbench
